// >>> include/ftwd_params.svh
// Offsets, field positions, masks and reset values of the trim word decoder
`ifndef FTWD_PARAMS_SVH
`define FTWD_PARAMS_SVH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define FTWD_IDX_W        14
`define FTWD_PRI_IDX      14'h2008
`define FTWD_SEC_IDX      14'h2009
`define FTWD_CTRL_IDX     14'h2000
`define FTWD_PC_IDX       14'h2001
`define FTWD_STAT_IDX     14'h2002

// ****************************************
// Word layout
// ****************************************
`define FTWD_WORD_W       14
`define FTWD_PRI_MASK     14'h1FFF
`define FTWD_SEC_MASK     14'h003F
`define FTWD_ERASED       14'h3FFF
`define FTWD_OSC_MSB      12
`define FTWD_OSC_LSB      6
`define FTWD_HI_MSB       5
`define FTWD_HI_LSB       3
`define FTWD_LO_MSB       2
`define FTWD_LO_LSB       0
`define FTWD_CTRL_ERASE   0
`define FTWD_STAT_LOADED  0

// ****************************************
// Reset values
// ****************************************
`define FTWD_PC_RST       14'h0000
`define FTWD_FACTORY_PRI  14'h0000
`define FTWD_FACTORY_SEC  14'h0000

`endif

// >>> include/ftwd_pkg.sv
// Types and the threshold decode function of the trim word decoder
package ftwd_pkg;

  // ****************************************
  // Loader states
  // ****************************************
  typedef enum logic [1:0] {
    ST_LOAD_PRI = 2'b00,
    ST_LOAD_SEC = 2'b01,
    ST_LOAD_FIN = 2'b10,
    ST_RUN      = 2'b11
  } ftwd_state_t;

  typedef logic signed [2:0] ftwd_level_t;

  // Descending order 111,110,101,100/000,001,010,011 mapped to +3..-3
  function automatic ftwd_level_t threshold_level(input logic [2:0] code);
    ftwd_level_t lvl;
    lvl = 3'sh0;
    case (code)
      3'h7: lvl = 3'sh3;
      3'h6: lvl = 3'sh2;
      3'h5: lvl = 3'sh1;
      3'h1: lvl = -3'sh1;
      3'h2: lvl = -3'sh2;
      3'h3: lvl = -3'sh3;
      default: lvl = 3'sh0;
    endcase
    return lvl;
  endfunction

endpackage

// >>> rtl/ftwd_trim_store.sv
// Small nonvolatile-style store for the trim words with registered read data
`timescale 1ns/1ps
module ftwd_trim_store #(
  parameter int                 WIDTH = 14,
  parameter int                 DEPTH = 2,
  parameter int                 AW    = 1,
  parameter logic [WIDTH*DEPTH-1:0] INIT  = '0
) (
  // Clock and control
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Write port
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // Read port
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem      [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [WIDTH-1:0] next_rdata;

  // Write-first so a read right after a write sees the new word
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      next_mem[i] = mem[i];
      if (we && (waddr == AW'(i))) begin
        next_mem[i] = wdata;
      end
    end
    next_rdata = next_mem[raddr];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= INIT[i*WIDTH +: WIDTH];
      end
      rdata <= '0;
    end else if (ce) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= next_mem[i];
      end
      rdata <= next_rdata;
    end
  end

endmodule

// >>> rtl/ftwd_top.sv
// Factory trim word store, loader, decoder and AHB-Lite register slave
`timescale 1ns/1ps
`include "ftwd_params.svh"
module ftwd_top #(
  parameter logic [13:0] FACTORY_PRI = `FTWD_FACTORY_PRI,
  parameter logic [13:0] FACTORY_SEC = `FTWD_FACTORY_SEC
) (
  // Clock, reset, enable
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  // AHB-Lite slave
  input  wire logic                   hsel,
  input  wire logic [15:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic      [31:0]            hrdata,
  // Decoded trim codes
  output logic      [6:0]             osc_freq_trim,
  output logic                        osc_trim_active,
  output ftwd_pkg::ftwd_level_t       por_threshold_trim,
  output ftwd_pkg::ftwd_level_t       brownout_threshold_trim,
  output ftwd_pkg::ftwd_level_t       wakeup_reset_threshold_trim,
  output ftwd_pkg::ftwd_level_t       low_voltage_detect_trim,
  output logic                        trim_loaded
);

  // ****************************************
  // State
  // ****************************************
  ftwd_pkg::ftwd_state_t state, next_state;
  logic                  dp_valid, next_dp_valid;
  logic                  dp_write, next_dp_write;
  logic [13:0]           dp_idx, next_dp_idx;
  logic [13:0]           pc, next_pc;
  logic [6:0]            next_osc;
  ftwd_pkg::ftwd_level_t next_por, next_bod, next_wur, next_lvd;

  logic                  addr_take;
  logic [13:0]           addr_idx;
  logic                  mem_we;
  logic                  mem_waddr;
  logic [13:0]           mem_wdata;
  logic                  mem_raddr;
  logic [13:0]           mem_rdata;
  logic                  erase_fire;
  logic                  wr_phase;

  // ****************************************
  // Trim word store
  // ****************************************
  ftwd_trim_store #(
    .WIDTH (14),
    .DEPTH (2),
    .AW    (1),
    .INIT  ({FACTORY_SEC & `FTWD_SEC_MASK, FACTORY_PRI & `FTWD_PRI_MASK})
  ) u_store (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .raddr   (mem_raddr),
    .rdata   (mem_rdata)
  );

  // ****************************************
  // Bus slave
  // ****************************************
  // Bus is held off while the words load, so no access can race the loader
  assign hreadyout = ce && (state == ftwd_pkg::ST_RUN);
  assign hresp     = 1'b0;
  assign addr_idx  = haddr[15:2];
  assign addr_take = hsel && htrans[1] && hready;
  assign wr_phase  = dp_valid && dp_write && ce;

  always_comb begin
    next_dp_valid = dp_valid;
    next_dp_write = dp_write;
    next_dp_idx   = dp_idx;
    if (hready) begin
      next_dp_valid = addr_take;
      next_dp_write = hwrite;
      next_dp_idx   = addr_idx;
    end
  end

  assign erase_fire = wr_phase && (dp_idx == `FTWD_CTRL_IDX) && hwdata[`FTWD_CTRL_ERASE];

  // Trim words change only by programming, a bulk erase aimed at them, or reset, which reloads the masked factory values
  always_comb begin
    mem_we    = 1'b0;
    mem_waddr = 1'b0;
    mem_wdata = '0;
    if (wr_phase && (dp_idx == `FTWD_PRI_IDX)) begin
      mem_we    = 1'b1;
      mem_wdata = hwdata[13:0] & `FTWD_PRI_MASK;
    end else if (wr_phase && (dp_idx == `FTWD_SEC_IDX)) begin
      mem_we    = 1'b1;
      mem_waddr = 1'b1;
      mem_wdata = hwdata[13:0] & `FTWD_SEC_MASK;
    end else if (erase_fire && (pc == `FTWD_PRI_IDX)) begin
      mem_we    = 1'b1;
      mem_wdata = `FTWD_ERASED & `FTWD_PRI_MASK;
    end else if (erase_fire && (pc == `FTWD_SEC_IDX)) begin
      mem_we    = 1'b1;
      mem_waddr = 1'b1;
      mem_wdata = `FTWD_ERASED & `FTWD_SEC_MASK;
    end
  end

  always_comb begin
    next_pc = pc;
    if (wr_phase && (dp_idx == `FTWD_PC_IDX)) begin
      next_pc = hwdata[13:0];
    end
  end

  // Read data: unimplemented bits come back as zero
  always_comb begin
    hrdata = 32'h0000_0000;
    if (dp_valid && !dp_write) begin
      if (dp_idx == `FTWD_PRI_IDX) begin
        hrdata = {18'h0, mem_rdata & `FTWD_PRI_MASK};
      end else if (dp_idx == `FTWD_SEC_IDX) begin
        hrdata = {18'h0, mem_rdata & `FTWD_SEC_MASK};
      end else if (dp_idx == `FTWD_PC_IDX) begin
        hrdata = {18'h0, pc};
      end else if (dp_idx == `FTWD_STAT_IDX) begin
        hrdata = {31'h0, trim_loaded};
      end
    end
  end

  // ****************************************
  // Loader and decoder
  // ****************************************
  always_comb begin
    next_state = state;
    next_osc   = osc_freq_trim;
    next_por   = por_threshold_trim;
    next_bod   = brownout_threshold_trim;
    next_wur   = wakeup_reset_threshold_trim;
    next_lvd   = low_voltage_detect_trim;
    mem_raddr  = (addr_idx == `FTWD_SEC_IDX);
    case (state)
      ftwd_pkg::ST_LOAD_PRI: begin
        mem_raddr  = 1'b0;
        next_state = ftwd_pkg::ST_LOAD_SEC;
      end
      ftwd_pkg::ST_LOAD_SEC: begin
        mem_raddr  = 1'b1;
        next_osc   = mem_rdata[`FTWD_OSC_MSB:`FTWD_OSC_LSB];
        next_por   = ftwd_pkg::threshold_level(mem_rdata[`FTWD_HI_MSB:`FTWD_HI_LSB]);
        next_bod   = ftwd_pkg::threshold_level(mem_rdata[`FTWD_LO_MSB:`FTWD_LO_LSB]);
        next_state = ftwd_pkg::ST_LOAD_FIN;
      end
      ftwd_pkg::ST_LOAD_FIN: begin
        next_wur   = ftwd_pkg::threshold_level(mem_rdata[`FTWD_HI_MSB:`FTWD_HI_LSB]);
        next_lvd   = ftwd_pkg::threshold_level(mem_rdata[`FTWD_LO_MSB:`FTWD_LO_LSB]);
        next_state = ftwd_pkg::ST_RUN;
      end
      default: begin
        // Decoded codes frozen until the next reset, even if software reprograms
        next_state = ftwd_pkg::ST_RUN;
      end
    endcase
  end

  assign trim_loaded     = (state == ftwd_pkg::ST_RUN);
  assign osc_trim_active = (osc_freq_trim != 7'h00);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state                       <= ftwd_pkg::ST_LOAD_PRI;
      dp_valid                    <= 1'b0;
      dp_write                    <= 1'b0;
      dp_idx                      <= 14'h0000;
      pc                          <= `FTWD_PC_RST;
      osc_freq_trim               <= 7'h00;
      por_threshold_trim          <= 3'sh0;
      brownout_threshold_trim     <= 3'sh0;
      wakeup_reset_threshold_trim <= 3'sh0;
      low_voltage_detect_trim     <= 3'sh0;
    end else if (ce) begin
      state                       <= next_state;
      dp_valid                    <= next_dp_valid;
      dp_write                    <= next_dp_write;
      dp_idx                      <= next_dp_idx;
      pc                          <= next_pc;
      osc_freq_trim               <= next_osc;
      por_threshold_trim          <= next_por;
      brownout_threshold_trim     <= next_bod;
      wakeup_reset_threshold_trim <= next_wur;
      low_voltage_detect_trim     <= next_lvd;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_osc_capture: assert property (
    (ce && state == ftwd_pkg::ST_LOAD_SEC) |=> (osc_freq_trim == $past(mem_rdata[12:6])))
    else $error("oscillator trim not taken from primary bits 12..6");
  chk_osc_centre: assert property (
    (ce && state == ftwd_pkg::ST_LOAD_SEC && mem_rdata[12:6] == 7'h00) |=> !osc_trim_active)
    else $error("zero oscillator trim still flags an offset");
  chk_por_order: assert property (
    (ce && state == ftwd_pkg::ST_LOAD_SEC && mem_rdata[5:3] == 3'h3) |=> (por_threshold_trim == -3'sh3))
    else $error("power-on code 011 not decoded as lowest");
  chk_bod_centre: assert property (
    (ce && state == ftwd_pkg::ST_LOAD_SEC && (mem_rdata[2:0] == 3'h4 || mem_rdata[2:0] == 3'h0))
      |=> (brownout_threshold_trim == 3'sh0))
    else $error("brown-out centre codes not decoded as centre");
  chk_pri_bit13: assert property (
    (dp_valid && !dp_write && dp_idx == `FTWD_PRI_IDX) |-> (hrdata[31:13] == 19'h0))
    else $error("primary word bit 13 read as one");
  chk_wur_top: assert property (
    (ce && state == ftwd_pkg::ST_LOAD_FIN && mem_rdata[5:3] == 3'h7) |=> (wakeup_reset_threshold_trim == 3'sh3))
    else $error("wake-up code 111 not decoded as highest");
  chk_lvd_step: assert property (
    (ce && state == ftwd_pkg::ST_LOAD_FIN && mem_rdata[2:0] == 3'h1) |=> (low_voltage_detect_trim == -3'sh1))
    else $error("low-voltage code 001 not one step below centre");
  chk_sec_upper: assert property (
    (dp_valid && !dp_write && dp_idx == `FTWD_SEC_IDX) |-> (hrdata[31:6] == 26'h0))
    else $error("secondary word upper bits read as one");
  chk_pri_spared: assert property (
    (erase_fire && pc != `FTWD_PRI_IDX) |-> !(mem_we && !mem_waddr))
    else $error("primary word erased with program counter elsewhere");
  chk_sec_spared: assert property (
    (erase_fire && pc != `FTWD_SEC_IDX) |-> !(mem_we && mem_waddr))
    else $error("secondary word erased with program counter elsewhere");
  chk_codes_hold: assert property (
    (state == ftwd_pkg::ST_RUN) |=> ($stable(osc_freq_trim) && $stable(por_threshold_trim)
      && $stable(brownout_threshold_trim) && $stable(wakeup_reset_threshold_trim)
      && $stable(low_voltage_detect_trim)))
    else $error("decoded trim changed after load");
  chk_load_time: assert property (
    $fell(rst) |-> ##[1:3] trim_loaded)
    else $error("trim load did not finish in three cycles");

  cov_loaded:    cover property ($rose(trim_loaded));
  cov_erase_pri: cover property (erase_fire && pc == `FTWD_PRI_IDX);
  cov_erase_sec: cover property (erase_fire && pc == `FTWD_SEC_IDX);
  cov_read_pri:  cover property (dp_valid && !dp_write && dp_idx == `FTWD_PRI_IDX);

endmodule

// >>> tb/ftwd_programmer.sv
// Programmer model: AHB-Lite master that reads, bulk-erases and restores trim words
`timescale 1ns/1ps
`include "ftwd_params.svh"
module ftwd_programmer (
  // Clock
  input  wire logic        ref_clk,
  // Slave answer
  input  wire logic        hreadyout,
  input  wire logic [31:0] hrdata,
  // Master request
  output logic             hsel,
  output logic [15:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 16'h0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // Each phase ends at the rising edge that samples hreadyout high; read data is taken at that same edge
  task automatic xfer(input logic wr, input logic [13:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    if (wr) hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Trims are saved as read: no value or range is assumed for them
  task automatic erase(input logic [13:0] pc, input logic keep);
    logic [31:0] pri;
    logic [31:0] sec;
    logic [31:0] rd;
    pri = 32'h0;
    sec = 32'h0;
    if (keep) begin
      xfer(1'b0, `FTWD_PRI_IDX, 32'h0, pri);
      xfer(1'b0, `FTWD_SEC_IDX, 32'h0, sec);
    end
    xfer(1'b1, `FTWD_PC_IDX, {18'h0, pc}, rd);
    xfer(1'b1, `FTWD_CTRL_IDX, 32'h1, rd);
    if (keep) begin
      xfer(1'b1, `FTWD_PRI_IDX, pri, rd);
      xfer(1'b1, `FTWD_SEC_IDX, sec, rd);
    end
  endtask
endmodule

// >>> tb/factory_trim_word_decoder_test.sv
// Testbench: factory load, level decode, register access and bulk erase of the trim words
`timescale 1ns/1ps
`include "ftwd_params.svh"
module factory_trim_word_decoder_test;
  localparam logic [6:0] OSC_TAB [8] = '{7'h3F, 7'h40, 7'h00, 7'h01, 7'h7F, 7'h20, 7'h5A, 7'h11};
  logic                  ref_clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  ce = 1'b1;
  logic                  hsel, hwrite, hreadyout, hresp, osc_on, loaded;
  logic [15:0]           haddr;
  logic [1:0]            htrans;
  logic [2:0]            hsize;
  logic [31:0]           hwdata, hrdata, rd;
  logic [6:0]            osc;
  ftwd_pkg::ftwd_level_t por, bod, wur, lvd;
  logic [6:0]            g_osc [8];
  logic                  g_on [8];
  ftwd_pkg::ftwd_level_t g_lv [8][4];
  int                    n_fail = 0;
  int                    n_tests = 0;

  always #20 ref_clk = ~ref_clk;

  ftwd_programmer prog (.ref_clk(ref_clk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // Upper bits set in the factory words must never read back
  ftwd_top #(.FACTORY_PRI(14'h301F), .FACTORY_SEC(14'h3FCC)) DUT (.ref_clk(ref_clk), .rst(rst), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .osc_freq_trim(osc),
    .osc_trim_active(osc_on), .por_threshold_trim(por), .brownout_threshold_trim(bod),
    .wakeup_reset_threshold_trim(wur), .low_voltage_detect_trim(lvd), .trim_loaded(loaded));

  // One decoder per code, so every threshold code and several oscillator codes are seen
  for (genvar i = 0; i < 8; i++) begin : g_lvl
    ftwd_top #(.FACTORY_PRI({1'b1, OSC_TAB[i], 3'(i), 3'(7 - i)}), .FACTORY_SEC({8'hFF, 3'(i), 3'(i + 3)})) DUT (
      .ref_clk(ref_clk), .rst(rst), .ce(ce), .hsel(1'b0), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(), .hresp(), .hrdata(),
      .osc_freq_trim(g_osc[i]), .osc_trim_active(g_on[i]), .por_threshold_trim(g_lv[i][0]),
      .brownout_threshold_trim(g_lv[i][1]), .wakeup_reset_threshold_trim(g_lv[i][2]),
      .low_voltage_detect_trim(g_lv[i][3]), .trim_loaded());
  end

  function automatic ftwd_pkg::ftwd_level_t lvl(input logic [2:0] c);
    return c[2] ? {1'b0, c[1:0]} : 3'(-{1'b0, c[1:0]});
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic rd_chk(input logic [13:0] idx, input logic [31:0] exp);
    prog.xfer(1'b0, idx, 32'h0, rd);
    check(rd, exp);
    check({31'h0, hresp}, 32'h0);
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    check(hreadyout, 1'b0);
    check({loaded, osc}, 8'h00);
    @(posedge ref_clk);
    rst <= 1'b0;
    for (int k = 0; k < 10 && loaded !== 1'b1; k++) @(negedge ref_clk);
    check(loaded, 1'b1);
  endtask

  task automatic t_load();
    check(osc, 7'h40);
    check(osc_on, 1'b1);
    check({por, bod}, {lvl(3'h3), lvl(3'h7)});
    check({wur, lvd}, {lvl(3'h1), lvl(3'h4)});
    rd_chk(`FTWD_PRI_IDX, 32'h101F);
    rd_chk(`FTWD_SEC_IDX, 32'h000C);
    rd_chk(`FTWD_STAT_IDX, 32'h0001);
    $display("t_load done");
  endtask

  task automatic t_levels();
    for (int i = 0; i < 8; i++) begin
      check(g_osc[i], OSC_TAB[i]);
      check(g_on[i], OSC_TAB[i] != 7'h00);
      check({g_lv[i][0], g_lv[i][1]}, {lvl(3'(i)), lvl(3'(7 - i))});
      check({g_lv[i][2], g_lv[i][3]}, {lvl(3'(i)), lvl(3'(i + 3))});
    end
    $display("t_levels done");
  endtask

  task automatic t_regs();
    prog.xfer(1'b1, `FTWD_PRI_IDX, 32'hFFFF_FFFF, rd);
    rd_chk(`FTWD_PRI_IDX, 32'h1FFF);
    prog.xfer(1'b1, `FTWD_SEC_IDX, 32'hFFFF_FFFF, rd);
    rd_chk(`FTWD_SEC_IDX, 32'h003F);
    check({osc, wur}, {7'h40, lvl(3'h1)});
    prog.xfer(1'b1, `FTWD_PC_IDX, 32'hFFFF_2ABC, rd);
    rd_chk(`FTWD_PC_IDX, 32'h2ABC);
    prog.xfer(1'b1, `FTWD_CTRL_IDX, 32'hFFFF_FFFE, rd);
    rd_chk(`FTWD_CTRL_IDX, 32'h0000);
    prog.xfer(1'b1, 14'h2005, 32'h1234_5678, rd);
    rd_chk(14'h2005, 32'h0000);
    rd_chk(`FTWD_PRI_IDX, 32'h1FFF);
    prog.xfer(1'b1, `FTWD_PRI_IDX, 32'h101F, rd);
    prog.xfer(1'b1, `FTWD_SEC_IDX, 32'h000C, rd);
    $display("t_regs done");
  endtask

  task automatic t_erase();
    prog.erase(14'h0000, 1'b0);
    rd_chk(`FTWD_PRI_IDX, 32'h101F);
    rd_chk(`FTWD_SEC_IDX, 32'h000C);
    prog.erase(`FTWD_SEC_IDX, 1'b0);
    rd_chk(`FTWD_SEC_IDX, 32'h003F);
    rd_chk(`FTWD_PRI_IDX, 32'h101F);
    prog.xfer(1'b1, `FTWD_SEC_IDX, 32'h000C, rd);
    prog.erase(`FTWD_PRI_IDX, 1'b1);
    rd_chk(`FTWD_PRI_IDX, 32'h101F);
    prog.erase(`FTWD_PRI_IDX, 1'b0);
    rd_chk(`FTWD_PRI_IDX, 32'h1FFF);
    rd_chk(`FTWD_SEC_IDX, 32'h000C);
    check({osc, por, lvd}, {7'h40, lvl(3'h3), lvl(3'h4)});
    prog.xfer(1'b1, `FTWD_PRI_IDX, 32'h101F, rd);
    $display("t_erase done");
  endtask

  task automatic t_hold();
    @(posedge ref_clk);
    ce <= 1'b0;
    @(negedge ref_clk);
    check({hreadyout, osc}, {1'b0, 7'h40});
    @(posedge ref_clk);
    ce <= 1'b1;
    do_reset();
    t_load();
    $display("t_hold done");
  endtask

  initial begin
    do_reset();
    t_load();
    t_levels();
    t_regs();
    t_erase();
    t_hold();
    conclude();
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    conclude();
  end
endmodule
